// ===== logic/i2c_ctl_pkg.sv
// -----------------------------------------------------------------------------
// Shared constants for the I2C master status and control block.
// -----------------------------------------------------------------------------
package i2c_ctl_pkg;

   // ---------------------------------------------------------------------------
   // Register map, byte addresses on the Avalon-MM slave.
   // ---------------------------------------------------------------------------
   localparam logic [3:0] STATUS_CONTROL_ADDR = 4'h0; // i2c_status_control.
   localparam logic [3:0] TX_DATA_ADDR = 4'h4;        // tx_data_register, push side.
   localparam logic [3:0] RX_DATA_ADDR = 4'h8;        // rx_data_register, read clears full.

   // ---------------------------------------------------------------------------
   // Field positions inside i2c_status_control.
   // ---------------------------------------------------------------------------
   localparam int STOP_AFTER_WRITE_BIT = 0;
   localparam int STOP_AFTER_READ_BIT = 1;
   localparam int TX_EMPTY_IRQ_ENABLE_BIT = 2;
   localparam int TX_EMPTY_FLAG_BIT = 3;
   localparam int FAST_SPEED_BIT = 4;
   localparam int BUS_ERROR_BIT = 5;
   localparam int RX_READY_IRQ_ENABLE_BIT = 6;
   localparam int RX_FULL_FLAG_BIT = 7;

   // Field positions inside a transmit command word.
   localparam int CMD_START_BIT = 8; // Issue a start condition before the byte.
   localparam int CMD_READ_BIT = 9;  // Receive a byte instead of sending one.
   localparam int CMD_WIDTH = 10;

   // Values after reset.
   localparam logic [7:0] STATUS_CONTROL_RESET = 8'h08; // Transmitter starts out empty.

   // ---------------------------------------------------------------------------
   // Bus timing: a bit is four quarter periods; least times round up.
   // ---------------------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int STD_BUS_HZ = 100_000;
   localparam int FAST_BUS_HZ = 400_000;
   localparam int QTR_STD_CYCLES = (CLK_HZ + 4 * STD_BUS_HZ - 1) / (4 * STD_BUS_HZ);
   localparam int QTR_FAST_CYCLES = (CLK_HZ + 4 * FAST_BUS_HZ - 1) / (4 * FAST_BUS_HZ);
   localparam int QTR_CNT_WIDTH = 10;
   localparam logic [3:0] ACK_SLOT = 4'h8; // Ninth clock of a byte carries the acknowledge.

   // Bit engine states.
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} engine_state_t;

endpackage

// ===== logic/sync_fifo.sv
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides.
// -----------------------------------------------------------------------------
module sync_fifo #(
   parameter int WIDTH = 10, // Width of one word.
   parameter int DEPTH = 8   // Number of words, a power of two.
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH]; // Word storage.
   logic [AW-1:0] wr_ptr_reg;         // Next slot to fill.
   logic [AW-1:0] rd_ptr_reg;         // Oldest word.
   logic [AW:0] count_reg;            // Words held, zero to DEPTH.
   logic push;
   logic pop;

   // Full and empty come straight from the count, so they are never optimistic.
   assign in_ready_o = (count_reg != AW'(0) + (AW + 1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // ---------------------------------------------------------------------------
   // Storage write; the array has no reset, only the pointers and the count do.
   // ---------------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // Pointer and count bookkeeping.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         // Simultaneous push and pop leave the count alone.
         if (push && !pop) begin
            count_reg <= count_reg + (AW + 1)'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - (AW + 1)'(1);
         end
      end
   end

endmodule // sync_fifo

// ===== logic/i2c_master_status_control.sv
`timescale 1ns/1ns
// Function
// [RULE1] Single bus master, no arbitration logic.
// [RULE2] Stop-after-write set: stop follows transmitted byte.
// [RULE3] Stop-after-read set: stop follows received byte.
// [RULE4] Transmit-empty enable gates the interrupt request.
// [RULE5] Status bits: flags, enables, bus error.
// [RULE6] Copy into shift register sets transmit empty.
// [RULE7] New transmit byte clears transmit empty.
// [RULE8] Missing acknowledge sets bus error; write one clears.
// [RULE9] Stop only after the acknowledge bit completes.
module i2c_master_status_control #(
   parameter int FIFO_DEPTH = 8 // Depth of the transmit command queue.
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic irq_request_o
);

   // --------------------------------------------------------------------------
   // Declarations.
   // --------------------------------------------------------------------------
   logic [7:0] ctl_reg;           // Status and control bits, flags included.
   logic [7:0] rx_data_reg;       // Last received byte.
   logic [31:0] readdata_reg;     // Registered read answer.
   logic waitrequest_reg;         // High except on the completing cycle.
   logic irq_reg;                 // Registered interrupt request.
   logic scl_oe_reg;              // High while we pull clock low.
   logic sda_oe_reg;              // High while we pull data low.
   logic accept;                  // A bus request completes this edge.
   logic wr_tx;                   // Write request to the transmit command address, low byte enabled.
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [i2c_ctl_pkg::CMD_WIDTH-1:0] fifo_out_data;
   logic pop;                     // Engine copies the queue head into the shifter.
   i2c_ctl_pkg::engine_state_t state_reg;
   logic [1:0] phase_reg;         // Quarter within the current bit.
   logic [3:0] bit_cnt_reg;       // Bit of the byte, ACK_SLOT is the acknowledge.
   logic [7:0] shift_reg;         // Byte being sent or collected.
   logic read_op_reg;             // Current byte is a receive.
   logic nack_reg;                // Acknowledge slot sampled high.
   logic [i2c_ctl_pkg::QTR_CNT_WIDTH-1:0] qtr_cnt_reg;
   logic tick;                    // One quarter bit has elapsed.
   logic ack_done;                // Last quarter of the acknowledge slot.
   logic want_stop;

   // The open-drain lines only ever pull low, so the data outputs are tied to constant zero.
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_oe_reg;
   assign sda_oe_o = sda_oe_reg;
   assign avs_readdata_o = readdata_reg;
   assign avs_waitrequest_o = waitrequest_reg;
   assign irq_request_o = irq_reg;

   // --------------------------------------------------------------------------
   // Avalon-MM slave. A request is answered one edge after it is seen; a
   // transmit write waits while the queue is full, which stalls software.
   // --------------------------------------------------------------------------
   assign wr_tx = avs_write_i && avs_address_i == i2c_ctl_pkg::TX_DATA_ADDR
      && avs_byteenable_i[0];
   assign accept = (avs_read_i || avs_write_i) && waitrequest_reg
      && !(wr_tx && !fifo_in_ready);

   // Handshake: drop waitrequest for exactly the completing edge.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         waitrequest_reg <= 1'b1;
      end else begin
         waitrequest_reg <= !accept;
      end
   end

   // Read answer; unmapped addresses read as zero.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         readdata_reg <= 32'h0;
      end else if (accept && avs_read_i) begin
         case (avs_address_i)
            i2c_ctl_pkg::STATUS_CONTROL_ADDR: readdata_reg <= {24'h0, ctl_reg}; // RULE5
            i2c_ctl_pkg::RX_DATA_ADDR: readdata_reg <= {24'h0, rx_data_reg};
            default: readdata_reg <= 32'h0;
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Status and control register. Hardware sets win over software clears so
   // that an event landing in the clearing cycle is never lost.
   // --------------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctl_reg <= i2c_ctl_pkg::STATUS_CONTROL_RESET;
      end else begin
         if (accept && avs_write_i && avs_byteenable_i[0]
            && avs_address_i == i2c_ctl_pkg::STATUS_CONTROL_ADDR) begin
            // Plain read/write fields.
            ctl_reg[i2c_ctl_pkg::STOP_AFTER_WRITE_BIT] <= avs_writedata_i[0];
            ctl_reg[i2c_ctl_pkg::STOP_AFTER_READ_BIT] <= avs_writedata_i[1];
            ctl_reg[i2c_ctl_pkg::TX_EMPTY_IRQ_ENABLE_BIT] <= avs_writedata_i[2];
            ctl_reg[i2c_ctl_pkg::FAST_SPEED_BIT] <= avs_writedata_i[4];
            ctl_reg[i2c_ctl_pkg::RX_READY_IRQ_ENABLE_BIT] <= avs_writedata_i[6];
            // Bus error clears on a written one only.
            if (avs_writedata_i[i2c_ctl_pkg::BUS_ERROR_BIT]) begin
               ctl_reg[i2c_ctl_pkg::BUS_ERROR_BIT] <= 1'b0; // RULE8
            end
         end
         // A new transmit byte means the transmitter is no longer empty.
         if (accept && wr_tx) begin
            ctl_reg[i2c_ctl_pkg::TX_EMPTY_FLAG_BIT] <= 1'b0; // RULE7
         end
         // Reading the receive byte releases the receiver.
         if (accept && avs_read_i && avs_address_i == i2c_ctl_pkg::RX_DATA_ADDR) begin
            ctl_reg[i2c_ctl_pkg::RX_FULL_FLAG_BIT] <= 1'b0;
         end
         // Hardware events, placed last so they take priority.
         if (pop) begin
            ctl_reg[i2c_ctl_pkg::TX_EMPTY_FLAG_BIT] <= 1'b1; // RULE6
         end
         if (ack_done && tick && read_op_reg) begin
            ctl_reg[i2c_ctl_pkg::RX_FULL_FLAG_BIT] <= 1'b1; // RULE5
         end
         if (ack_done && tick && !read_op_reg && nack_reg) begin
            ctl_reg[i2c_ctl_pkg::BUS_ERROR_BIT] <= 1'b1; // RULE8
         end
      end
   end

   // Interrupt request: each flag only counts while its enable is set.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (ctl_reg[i2c_ctl_pkg::TX_EMPTY_FLAG_BIT]
            && ctl_reg[i2c_ctl_pkg::TX_EMPTY_IRQ_ENABLE_BIT]) // RULE4
            || (ctl_reg[i2c_ctl_pkg::RX_FULL_FLAG_BIT]
            && ctl_reg[i2c_ctl_pkg::RX_READY_IRQ_ENABLE_BIT]);
      end
   end

   // --------------------------------------------------------------------------
   // Transmit command queue between software and the shifter.
   // --------------------------------------------------------------------------
   sync_fifo #(
      .WIDTH(i2c_ctl_pkg::CMD_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) sync_fifo_inst (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_data_i(avs_writedata_i[i2c_ctl_pkg::CMD_WIDTH-1:0]),
      .in_valid_i(accept && wr_tx),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop)
   );

   // The engine takes the next word only while idle, so a slow bus backs up
   // the queue and eventually holds the Avalon master in waitrequest.
   assign pop = (state_reg == i2c_ctl_pkg::ST_IDLE) && fifo_out_valid;

   // --------------------------------------------------------------------------
   // Quarter-bit timer; speed bit picks standard or fast mode.
   // --------------------------------------------------------------------------
   assign tick = (qtr_cnt_reg == '0);

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         qtr_cnt_reg <= '0;
      end else if (tick || state_reg == i2c_ctl_pkg::ST_IDLE) begin
         qtr_cnt_reg <= ctl_reg[i2c_ctl_pkg::FAST_SPEED_BIT]
            ? i2c_ctl_pkg::QTR_CNT_WIDTH'(i2c_ctl_pkg::QTR_FAST_CYCLES - 1)
            : i2c_ctl_pkg::QTR_CNT_WIDTH'(i2c_ctl_pkg::QTR_STD_CYCLES - 1);
      end else begin
         qtr_cnt_reg <= qtr_cnt_reg - i2c_ctl_pkg::QTR_CNT_WIDTH'(1);
      end
   end

   // --------------------------------------------------------------------------
   // Bit engine. We are the only master: the clock is driven from our own
   // timer and never compared with scl_i, and no arbitration is tracked.
   // --------------------------------------------------------------------------
   assign ack_done = (state_reg == i2c_ctl_pkg::ST_BIT) && (bit_cnt_reg == i2c_ctl_pkg::ACK_SLOT)
      && (phase_reg == 2'd3);
   assign want_stop = read_op_reg ? ctl_reg[i2c_ctl_pkg::STOP_AFTER_READ_BIT] // RULE3
      : ctl_reg[i2c_ctl_pkg::STOP_AFTER_WRITE_BIT] || nack_reg; // RULE2

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= i2c_ctl_pkg::ST_IDLE;
         phase_reg <= 2'd0;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h0;
         read_op_reg <= 1'b0;
         nack_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         rx_data_reg <= 8'h0;
      end else begin
         case (state_reg)
            i2c_ctl_pkg::ST_IDLE: begin
               // Copy the queue head into the shifter; clock stays where it was.
               if (pop) begin
                  shift_reg <= fifo_out_data[7:0];
                  read_op_reg <= fifo_out_data[i2c_ctl_pkg::CMD_READ_BIT];
                  nack_reg <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  phase_reg <= 2'd0;
                  state_reg <= fifo_out_data[i2c_ctl_pkg::CMD_START_BIT]
                     ? i2c_ctl_pkg::ST_START : i2c_ctl_pkg::ST_BIT;
               end
            end
            i2c_ctl_pkg::ST_START: begin
               // Release data, release clock, pull data low, then pull clock low.
               if (tick) begin
                  phase_reg <= phase_reg + 2'd1;
                  case (phase_reg)
                     // Data goes up while the clock may still be held low, so a
                     // repeated start never looks like a stop on the wires.
                     2'd0: sda_oe_reg <= 1'b0;
                     2'd1: scl_oe_reg <= 1'b0;
                     2'd2: sda_oe_reg <= 1'b1;
                     default: begin
                        scl_oe_reg <= 1'b1; // RULE1
                        state_reg <= i2c_ctl_pkg::ST_BIT;
                     end
                  endcase
               end
            end
            i2c_ctl_pkg::ST_BIT: begin
               // Data changes in the first quarter, while the clock is low unless a stop or reset left it released.
               if (tick) begin
                  phase_reg <= phase_reg + 2'd1;
                  case (phase_reg)
                     2'd0: begin
                        if (bit_cnt_reg == i2c_ctl_pkg::ACK_SLOT) begin
                           // We acknowledge a received byte unless a stop follows.
                           sda_oe_reg <= read_op_reg
                              && !ctl_reg[i2c_ctl_pkg::STOP_AFTER_READ_BIT];
                        end else begin
                           sda_oe_reg <= !read_op_reg && !shift_reg[7];
                        end
                     end
                     2'd1: scl_oe_reg <= 1'b0;
                     2'd2: begin
                        if (bit_cnt_reg == i2c_ctl_pkg::ACK_SLOT) begin
                           nack_reg <= sda_i;
                        end else begin
                           shift_reg <= {shift_reg[6:0], sda_i};
                        end
                     end
                     default: begin
                        scl_oe_reg <= 1'b1;
                        if (bit_cnt_reg == i2c_ctl_pkg::ACK_SLOT) begin
                           // The acknowledge clock is over; only now may a stop go out.
                           if (read_op_reg) begin
                              rx_data_reg <= shift_reg;
                           end
                           state_reg <= want_stop ? i2c_ctl_pkg::ST_STOP // RULE9
                              : i2c_ctl_pkg::ST_IDLE;
                        end else begin
                           bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                     end
                  endcase
               end
            end
            i2c_ctl_pkg::ST_STOP: begin
               // Pull data low, release clock, then release data.
               if (tick) begin
                  phase_reg <= phase_reg + 2'd1;
                  case (phase_reg)
                     2'd0: sda_oe_reg <= 1'b1;
                     2'd1: scl_oe_reg <= 1'b0;
                     2'd2: sda_oe_reg <= 1'b0;
                     default: state_reg <= i2c_ctl_pkg::ST_IDLE;
                  endcase
               end
            end
            default: state_reg <= i2c_ctl_pkg::ST_IDLE;
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Assertions.
   // --------------------------------------------------------------------------
   a_data_stable_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE1
      (state_reg == i2c_ctl_pkg::ST_BIT && !scl_oe_reg && $past(!scl_oe_reg))
      |-> $stable(sda_oe_reg))
      else $error("Data line moved while clock was high.");
   a_stop_after_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE2
      (ack_done && tick && !read_op_reg && ctl_reg[0]) |=> state_reg == i2c_ctl_pkg::ST_STOP)
      else $error("No stop after transmitted byte.");
   a_no_write_stop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE2
      (ack_done && tick && !read_op_reg && !ctl_reg[0] && !nack_reg)
      |=> state_reg == i2c_ctl_pkg::ST_IDLE)
      else $error("Unexpected stop after transmitted byte.");
   a_stop_after_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE3
      (ack_done && tick && read_op_reg) |=> (state_reg == i2c_ctl_pkg::ST_STOP) == $past(ctl_reg[1]))
      else $error("Stop after received byte does not follow its enable.");
   a_tx_irq_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE4
      (!ctl_reg[2] && !(ctl_reg[7] && ctl_reg[6])) |=> !irq_request_o)
      else $error("Interrupt raised while disabled.");
   a_status_readback: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE5
      (accept && avs_read_i && avs_address_i == i2c_ctl_pkg::STATUS_CONTROL_ADDR)
      |=> avs_readdata_o[7:0] == $past(ctl_reg) && !avs_waitrequest_o)
      else $error("Status read returned wrong value.");
   a_tx_empty_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE6
      pop |=> ctl_reg[3])
      else $error("Transmit empty not set on copy.");
   a_tx_empty_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE7
      (accept && wr_tx && !pop) |=> !ctl_reg[3])
      else $error("Transmit empty not cleared by new byte.");
   a_bus_error_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE8
      (ack_done && tick && !read_op_reg && nack_reg) |=> ctl_reg[5] && state_reg == i2c_ctl_pkg::ST_STOP)
      else $error("Missing acknowledge not reported.");
   a_stop_after_ack: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE9
      $rose(state_reg == i2c_ctl_pkg::ST_STOP) |-> $past(bit_cnt_reg) == i2c_ctl_pkg::ACK_SLOT
      && $past(phase_reg) == 2'd3 && scl_oe_reg)
      else $error("Stop began before the acknowledge finished.");

endmodule // i2c_master_status_control

// ===== verif/i2c_slave_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Slave device on the two-wire bus.
// ----------------------------------------
module i2c_slave_model (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic ack_en_i,
   output logic sda_pull_o = 1'b0,
   output int stop_cnt_o = 0,
   output int ack_cnt_o = 0
);
   int bits = 0; // Clock pulses seen in the current byte.
   int idx = 0; // Byte index since the last start.
   logic rd = 1'b0; // Direction bit; a read byte is never acknowledged by us.
   // Falling data while the clock is high is a start; it restarts counting.
   always @(negedge sda_i) if (scl_i === 1'b1) begin
      bits = 0;
      idx = 0;
   end
   // Rising data while the clock is high is a stop.
   always @(posedge sda_i) if (scl_i === 1'b1) stop_cnt_o++;
   // Sample on the rising clock; the direction bit ends byte zero.
   always @(posedge scl_i) begin
      if (bits == 7 && idx == 0) rd = sda_i;
      if (bits == 8 && sda_pull_o) ack_cnt_o++;
      bits = (bits == 8) ? 0 : bits + 1;
      if (bits == 0) idx++;
   end
   // Change the data pull only on the falling clock, so no false start is made.
   always @(negedge scl_i) sda_pull_o <= bits == 8 && ack_en_i && (idx == 0 || !rd);
endmodule // i2c_slave_model

// ===== verif/i2c_master_status_control_tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the status and control block.
// ----------------------------------------
module i2c_master_status_control_tb_top;
   logic sys_clk_i = 1'b0; // 250 MHz system clock.
   logic sys_rst_i = 1'b1; // Reset, held for three cycles.
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, q;
   logic wait_req, scl_d, scl_oe, sda_d, sda_oe, irq, pull;
   logic ack_en = 1'b1; // Cleared to make the slave stay silent.
   wire logic scl = !scl_oe; // Pull-ups hold released lines high.
   wire logic sda = !(sda_oe || pull);
   int fail_count = 0;
   int checks = 0;
   int stop_cnt, ack_cnt, stops, acks;
   localparam logic [3:0] SC = i2c_ctl_pkg::STATUS_CONTROL_ADDR;
   localparam logic [3:0] TX = i2c_ctl_pkg::TX_DATA_ADDR;
   i2c_master_status_control #(.FIFO_DEPTH(8)) i2c_master_status_control_inst (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'h1), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
      .scl_i(scl), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_d),
      .sda_oe_o(sda_oe), .irq_request_o(irq));
   i2c_slave_model i2c_slave_model_inst (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en),
      .sda_pull_o(pull), .stop_cnt_o(stop_cnt), .ack_cnt_o(ack_cnt));
   initial forever #2 sys_clk_i = !sys_clk_i;
   // ----------------------------------------
   // Shared tasks.
   // ----------------------------------------
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One bus cycle, held until waitrequest is sampled low; read data lands in q.
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk_i);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      for (n = 0; n < 64 && wait_req !== 1'b0; n++) @(posedge sys_clk_i);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 64) begin
         fail_count++;
         stop_test;
      end
   endtask
   // Waits, bounded, for an acknowledge or a stop count to pass its base.
   task wait_cnt(input bit ack, input int base);
      int n;
      for (n = 0; n < 40000 && (ack ? ack_cnt : stop_cnt) <= base; n++) @(posedge sys_clk_i);
      if (n == 40000) begin
         fail_count++;
         stop_test;
      end
   endtask
   // ----------------------------------------
   // Scenarios.
   // ----------------------------------------
   task test_regs;
      bus(0, SC, 0);
      check("status", q, 32'h08);
      bus(0, 4'hc, 0);
      check("unmapped", q, 32'h0);
      check("line drive", {30'h0, scl_d, sda_d}, 32'h0);
      bus(1, SC, 32'h14);
      repeat (3) @(posedge sys_clk_i);
      check("irq on", {31'h0, irq}, 32'h1);
      bus(1, SC, 32'h10);
      repeat (3) @(posedge sys_clk_i);
      check("irq off", {31'h0, irq}, 32'h0);
      $display("test regs done");
   endtask
   task test_write;
      stops = stop_cnt;
      acks = ack_cnt;
      bus(1, TX, 32'h1a0);
      wait_cnt(1, acks);
      repeat (1000) @(posedge sys_clk_i);
      check("no stop", stop_cnt, stops);
      bus(0, SC, 0);
      check("tx empty", q, 32'h18);
      bus(1, SC, 32'h11);
      bus(1, TX, 32'h055);
      wait_cnt(0, stops);
      check("acks", ack_cnt, acks + 2);
      bus(0, SC, 0);
      check("after stop", q, 32'h19);
      $display("test write done");
   endtask
   task test_nack;
      ack_en <= 1'b0;
      stops = stop_cnt;
      bus(1, TX, 32'h1a0);
      wait_cnt(0, stops);
      bus(0, SC, 0);
      check("error set", q, 32'h39);
      bus(1, SC, 32'h11);
      bus(0, SC, 0);
      check("zero keeps", q, 32'h39);
      bus(1, SC, 32'h31);
      bus(0, SC, 0);
      check("one clears", q, 32'h19);
      ack_en <= 1'b1;
      $display("test nack done");
   endtask
   task test_read;
      bus(1, SC, 32'h12);
      stops = stop_cnt;
      bus(1, TX, 32'h1a1);
      bus(1, TX, 32'h200);
      wait_cnt(0, stops);
      bus(0, SC, 0);
      check("rx full", q, 32'h9a);
      bus(0, i2c_ctl_pkg::RX_DATA_ADDR, 0);
      check("rx data", q, 32'hff);
      bus(0, SC, 0);
      check("rx cleared", q, 32'h1a);
      $display("test read done");
   endtask
   initial begin
      repeat (3) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      test_regs();
      test_write();
      test_nack();
      test_read();
      stop_test();
   end
endmodule // i2c_master_status_control_tb_top
